// ===== verilog/tcc_pkg.sv
// Shared constants, types and register map of the tachometer control block
package tcc_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ       = 20_000_000;
    localparam int SAMPLE_MS    = 200;
    localparam int SAMPLE_CYC   = CLK_HZ / 1000 * SAMPLE_MS;
    localparam int SCALE_HZ     = 1000 / SAMPLE_MS;
    localparam int DEBOUNCE_US  = 5000;
    localparam int DEBOUNCE_CYC = CLK_HZ / 1_000_000 * DEBOUNCE_US;
    localparam int CAPT_CYC     = 3;

    // ------------------------------------------------------------------
    // Register map and field positions
    // ------------------------------------------------------------------
    localparam logic [7:0] REG_CMP1 = 8'h00;
    localparam logic [7:0] REG_CMP2 = 8'h04;
    localparam logic [7:0] REG_MEAS = 8'h08;
    localparam logic [7:0] REG_STAT = 8'h0c;
    localparam int STAT_DIP_LSB = 0;
    localparam int STAT_HOLD    = 8;
    localparam int STAT_OUT     = 9;
    localparam int STAT_KP      = 10;
    localparam int STAT_RUN     = 11;
    localparam int DIP_RATE     = 1;
    localparam int DIP_MODE_LSB = 2;
    localparam int DIP_AVG_LSB  = 4;
    localparam int DIP_PNP      = 7;
    localparam int MEAS_W       = 24;
    localparam logic [23:0] CMP_RESET = 24'h000000;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_HILO = 2'h0,
        MODE_AREA = 2'h1,
        MODE_HI   = 2'h2,
        MODE_LO   = 2'h3
    } tcc_mode_t;

    typedef enum logic [1:0] {
        ST_CAPT = 2'h1,
        ST_RUN  = 2'h2
    } tcc_state_t;

    typedef struct packed {
        logic      rate_hi;
        tcc_mode_t mode;
        logic [1:0] avg;
        logic      pnp;
    } tcc_cfg_t;

    typedef struct packed {
        logic       count;
        logic [2:0] hold;
        logic       hold_key;
        logic       keyprot;
        logic [7:0] dip;
    } tcc_pins_t;

    localparam tcc_cfg_t CFG_RESET = '{rate_hi: 1'b0, mode: MODE_HILO,
                                       avg: 2'h0, pnp: 1'b1};

endpackage

// ===== verilog/tcc_sync.sv
// Two-stage synchroniser for a bundle of asynchronous pin levels
`timescale 1ns/10ps
`default_nettype none
module tcc_sync #(
    parameter int WIDTH = 14
) (
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] pin_out
);

    logic [WIDTH-1:0] meta_q;

    if (WIDTH < 1) begin : g_chk
        $error("tcc_sync: WIDTH must be at least 1");
    end

    // First stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            meta_q  <= '0;
            pin_out <= '0;
        end else begin
            meta_q  <= pin_in;
            pin_out <= meta_q;
        end
    end

endmodule
`default_nettype wire

// ===== verilog/tcc_debounce.sv
// Optional contact-bounce filter: a level passes once stable long enough
`timescale 1ns/10ps
`default_nettype none
module tcc_debounce #(
    parameter int STABLE_CYC = 100000
) (
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic filt_en,
    input  wire logic lvl_in,
    output logic      lvl_out
);

    localparam int CW = $clog2(STABLE_CYC + 1);
    logic [CW-1:0] cnt_q;

    if (STABLE_CYC < 1) begin : g_chk
        $error("tcc_debounce: STABLE_CYC must be at least 1");
    end

    // Bypass when disabled; otherwise restart count on every change
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cnt_q   <= '0;
            lvl_out <= 1'b0;
        end else if (!filt_en || lvl_in == lvl_out) begin
            cnt_q   <= '0;
            lvl_out <= lvl_in;
        end else if (cnt_q == CW'(STABLE_CYC - 1)) begin
            cnt_q   <= '0;
            lvl_out <= lvl_in;
        end else begin
            cnt_q   <= cnt_q + CW'(1);
        end
    end

endmodule
`default_nettype wire

// ===== verilog/tcc_core.sv
// Tachometer measurement, compare output, hold and power-up configuration
//
// Contract
// - While hold is active the measurement value and control output freeze.
// - The hold indicator is on whenever any hold input or the hold key is on.
// - The hold key sustains the value and output exactly like hold inputs.
// - Each of the three independent hold inputs alone activates hold.
// - The control output follows the configured compare mode on the value.
// - Switch pair 3/4 selects hi-lo, area, upper or lower limit mode.
// - Switch pair 5/6 selects no averaging, 2, 4 or 8 samples.
// - Switches are taken only at power-up and ignored while running.
// - The output indicator is lit exactly while the control output is on.
// - The key protection indicator is lit while the protect switch is on.
// - The state of every switch bit can be read back for the operator.
// - Input polarity defaults to the voltage (sourcing) type.
// - One switch picks low or high count rate; low rate adds debouncing.
// - The chosen polarity applies alike to count and hold inputs.
//
// Design decisions made here: strobed register access and the address map.
`timescale 1ns/10ps
`default_nettype none
module tcc_core #(
    parameter int GATE_CYC     = tcc_pkg::SAMPLE_CYC,
    parameter int DEBOUNCE_CYC = tcc_pkg::DEBOUNCE_CYC
) (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        count_pin,
    input  wire logic [2:0]  hold_pin,
    input  wire logic        hold_key,
    input  wire logic        keyprot_sw,
    input  wire logic [7:0]  dip_sw,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr_stb,
    input  wire logic        rd_stb,
    output logic      [31:0] rdata,
    output logic             ctrl_out,
    output logic             led_hold,
    output logic             led_keyprot,
    output logic             led_out
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    localparam int GW = $clog2(GATE_CYC + 1);
    localparam int MW = tcc_pkg::MEAS_W;

    tcc_pkg::tcc_pins_t  pins_raw;
    tcc_pkg::tcc_pins_t  pins_s;
    tcc_pkg::tcc_cfg_t   cfg_q;
    tcc_pkg::tcc_state_t state_q;
    logic [1:0]    capt_cnt_q;
    logic          count_act;
    logic          count_flt;
    logic          count_prev_q;
    logic          count_edge;
    logic [2:0]    hold_act_pin;
    logic          hold_act;
    logic [GW-1:0] gate_cnt_q;
    logic          win_end;
    logic [15:0]   pulse_cnt_q;
    logic [15:0]   pulse_now;
    logic [2:0]    win_idx_q;
    logic [18:0]   sum_q;
    logic [18:0]   sum_new;
    logic [MW-1:0] meas_q;
    logic [MW-1:0] meas_new;
    logic          meas_load;
    logic [MW-1:0] cmp1_q;
    logic [MW-1:0] cmp2_q;
    logic          cmp_hit;
    logic [31:0]   rd_d;

    if (GATE_CYC < 8) begin : g_chk_gate
        $error("tcc_core: GATE_CYC too small");
    end
    if (DEBOUNCE_CYC < 1) begin : g_chk_deb
        $error("tcc_core: DEBOUNCE_CYC must be at least 1");
    end

    // ------------------------------------------------------------------
    // Pin synchronisation and polarity
    // ------------------------------------------------------------------
    assign pins_raw = '{count: count_pin, hold: hold_pin, hold_key: hold_key,
                        keyprot: keyprot_sw, dip: dip_sw};

    tcc_sync #(
        .WIDTH ($bits(tcc_pkg::tcc_pins_t))
    ) u_sync (
        .clk     (clk),
        .reset_n (reset_n),
        .pin_in  (pins_raw),
        .pin_out (pins_s)
    );

    // one polarity for count and hold inputs
    // Sinking inputs pull low when active, so invert unless sourcing
    assign count_act    = pins_s.count ^ ~cfg_q.pnp;
    assign hold_act_pin = pins_s.hold ^ {3{~cfg_q.pnp}};

    assign hold_act = (|hold_act_pin) | pins_s.hold_key;

    tcc_debounce #(
        .STABLE_CYC (DEBOUNCE_CYC)
    ) u_deb (
        .clk     (clk),
        .reset_n (reset_n),
        .filt_en (~cfg_q.rate_hi),
        .lvl_in  (count_act),
        .lvl_out (count_flt)
    );

    // ------------------------------------------------------------------
    // Power-up configuration capture
    // ------------------------------------------------------------------
    // capture once after reset
    // sourcing until capture
    // Waits for the synchroniser to fill before trusting the switches
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_q    <= tcc_pkg::ST_CAPT;
            capt_cnt_q <= 2'h0;
            cfg_q      <= tcc_pkg::CFG_RESET;
        end else begin
            unique case (state_q)
                tcc_pkg::ST_CAPT: begin
                    capt_cnt_q <= capt_cnt_q + 2'h1;
                    if (capt_cnt_q == 2'(tcc_pkg::CAPT_CYC)) begin
                        state_q       <= tcc_pkg::ST_RUN;
                        cfg_q.rate_hi <= pins_s.dip[tcc_pkg::DIP_RATE];
                        cfg_q.mode    <= tcc_pkg::tcc_mode_t'(
                            pins_s.dip[tcc_pkg::DIP_MODE_LSB +: 2]);
                        cfg_q.avg     <= pins_s.dip[tcc_pkg::DIP_AVG_LSB +: 2];
                        cfg_q.pnp     <= pins_s.dip[tcc_pkg::DIP_PNP];
                    end
                end
                tcc_pkg::ST_RUN: begin
                    capt_cnt_q <= capt_cnt_q;
                end
                default: begin
                    state_q <= tcc_pkg::ST_CAPT;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Sampling gate and pulse counting
    // ------------------------------------------------------------------
    assign count_edge = count_flt & ~count_prev_q;
    assign win_end    = (gate_cnt_q == GW'(GATE_CYC - 1));
    assign pulse_now  = pulse_cnt_q +
                        ((count_edge && pulse_cnt_q != 16'hffff) ? 16'h1
                                                                 : 16'h0);
    assign sum_new    = sum_q + {3'h0, pulse_now};

    // Gate timer counts only in run state
    always_ff @(posedge clk) begin
        if (!reset_n || state_q != tcc_pkg::ST_RUN || win_end) begin
            gate_cnt_q <= '0;
        end else begin
            gate_cnt_q <= gate_cnt_q + GW'(1);
        end
    end

    // Edge counter saturates rather than wrapping
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            count_prev_q <= 1'b0;
            pulse_cnt_q  <= 16'h0;
        end else begin
            count_prev_q <= count_flt;
            if (state_q != tcc_pkg::ST_RUN || win_end) begin
                pulse_cnt_q <= 16'h0;
            end else begin
                pulse_cnt_q <= pulse_now;
            end
        end
    end

    // ------------------------------------------------------------------
    // Averaging and measurement value
    // ------------------------------------------------------------------
    // Averaging by shift; counts are pulses per gate, scaled to Hz
    assign meas_load = win_end && (win_idx_q == 3'((1 << cfg_q.avg) - 1));
    assign meas_new  = MW'(({5'h0, sum_new} * MW'(tcc_pkg::SCALE_HZ))
                           >> cfg_q.avg);

    always_ff @(posedge clk) begin
        if (!reset_n || state_q != tcc_pkg::ST_RUN) begin
            win_idx_q <= 3'h0;
            sum_q     <= 19'h0;
        end else if (meas_load) begin
            win_idx_q <= 3'h0;
            sum_q     <= 19'h0;
        end else if (win_end) begin
            win_idx_q <= win_idx_q + 3'h1;
            sum_q     <= sum_new;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            meas_q <= '0;
        end else if (meas_load && !hold_act) begin
            meas_q <= meas_new;
        end
    end

    // ------------------------------------------------------------------
    // Compare output and indicators
    // ------------------------------------------------------------------
    // compare by mode
    // In hi-lo and area modes limit one is the upper bound, limit two the lower bound
    always_comb begin
        unique case (cfg_q.mode)
            tcc_pkg::MODE_HILO: cmp_hit = (meas_q >= cmp1_q) ||
                                          (meas_q <= cmp2_q);
            tcc_pkg::MODE_AREA: cmp_hit = (meas_q <= cmp1_q) &&
                                          (meas_q >= cmp2_q);
            tcc_pkg::MODE_HI:   cmp_hit = (meas_q >= cmp1_q);
            tcc_pkg::MODE_LO:   cmp_hit = (meas_q <= cmp1_q);
        endcase
    end

    always_ff @(posedge clk) begin
        if (!reset_n || state_q != tcc_pkg::ST_RUN) begin
            ctrl_out <= 1'b0;
            led_out  <= 1'b0;
        end else if (!hold_act) begin
            ctrl_out <= cmp_hit;
            led_out  <= cmp_hit;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            led_hold    <= 1'b0;
            led_keyprot <= 1'b0;
        end else begin
            led_hold    <= hold_act;
            led_keyprot <= pins_s.keyprot;
        end
    end

    // ------------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------------
    // Compare limits written by software
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cmp1_q <= tcc_pkg::CMP_RESET;
            cmp2_q <= tcc_pkg::CMP_RESET;
        end else if (wr_stb) begin
            if (addr == tcc_pkg::REG_CMP1) cmp1_q <= wdata[MW-1:0];
            if (addr == tcc_pkg::REG_CMP2) cmp2_q <= wdata[MW-1:0];
        end
    end

    // live switch readback
    // Shows present switch positions, not the captured set
    always_comb begin
        rd_d = 32'h0;
        unique case (addr)
            tcc_pkg::REG_CMP1: rd_d[MW-1:0] = cmp1_q;
            tcc_pkg::REG_CMP2: rd_d[MW-1:0] = cmp2_q;
            tcc_pkg::REG_MEAS: rd_d[MW-1:0] = meas_q;
            tcc_pkg::REG_STAT: begin
                rd_d[tcc_pkg::STAT_DIP_LSB +: 8] = pins_s.dip;
                rd_d[tcc_pkg::STAT_HOLD]         = led_hold;
                rd_d[tcc_pkg::STAT_OUT]          = ctrl_out;
                rd_d[tcc_pkg::STAT_KP]           = led_keyprot;
                rd_d[tcc_pkg::STAT_RUN]          = state_q == tcc_pkg::ST_RUN;
            end
            default: rd_d = 32'h0;
        endcase
    end

    // Read data valid in the cycle after each strobed cycle, zero otherwise
    always_ff @(posedge clk) begin
        if (!reset_n || !rd_stb) begin
            rdata <= 32'h0;
        end else begin
            rdata <= rd_d;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence s_hold_run;
        hold_act && state_q == tcc_pkg::ST_RUN;
    endsequence

    sequence s_capture;
        state_q == tcc_pkg::ST_CAPT && capt_cnt_q == 2'(tcc_pkg::CAPT_CYC);
    endsequence

    AST_HOLD_FREEZE: assert property (
        @(posedge clk) disable iff (!reset_n)
        s_hold_run |=> $stable(meas_q) && $stable(ctrl_out))
        else $error("value or output moved during hold");

    AST_HOLD_LAMP: assert property (
        @(posedge clk) disable iff (!reset_n)
        1'b1 |=> led_hold == $past((|hold_act_pin) || pins_s.hold_key))
        else $error("hold lamp differs from hold sources");

    AST_HOLD_KEY: assert property (
        @(posedge clk) disable iff (!reset_n)
        pins_s.hold_key [*2] |-> $stable(ctrl_out) && $stable(meas_q))
        else $error("hold key did not sustain output");

    AST_HOLD_PIN: assert property (
        @(posedge clk) disable iff (!reset_n)
        (|hold_act_pin) |=> led_hold)
        else $error("single hold terminal ignored");

    AST_COMPARE: assert property (
        @(posedge clk) disable iff (!reset_n)
        state_q == tcc_pkg::ST_RUN && !hold_act && $stable(state_q)
        |=> ctrl_out == $past(cmp_hit))
        else $error("control output does not follow compare");

    AST_MODE_DECODE: assert property (
        @(posedge clk) disable iff (!reset_n)
        s_capture |=> cfg_q.mode == $past(pins_s.dip[3:2]))
        else $error("output mode decode wrong");

    AST_AVG_LOAD: assert property (
        @(posedge clk) disable iff (!reset_n)
        win_end && state_q == tcc_pkg::ST_RUN && cfg_q.avg == 2'h3
        && win_idx_q != 3'h7 |-> !meas_load)
        else $error("averaging loaded before eight windows");

    AST_CFG_STABLE: assert property (
        @(posedge clk) disable iff (!reset_n)
        state_q == tcc_pkg::ST_RUN |=> $stable(cfg_q))
        else $error("configuration changed while running");

    AST_OUT_LAMP: assert property (
        @(posedge clk) disable iff (!reset_n)
        led_out == ctrl_out)
        else $error("output lamp differs from output");

    AST_KP_LAMP: assert property (
        @(posedge clk) disable iff (!reset_n)
        pins_s.keyprot ##1 pins_s.keyprot |-> led_keyprot)
        else $error("protect lamp off with switch on");

    AST_DEFAULT_PNP: assert property (
        @(posedge clk) disable iff (!reset_n)
        state_q == tcc_pkg::ST_CAPT |-> cfg_q.pnp)
        else $error("polarity not sourcing before capture");

    AST_RATE_FILTER: assert property (
        @(posedge clk) disable iff (!reset_n)
        cfg_q.rate_hi && $stable(cfg_q) |=> count_flt == $past(count_act))
        else $error("high rate path not bypassing filter");

endmodule
`default_nettype wire

// ===== verif/tcc_sensor_model.sv
// Field-side model: pulse sensor driving the count line
`timescale 1ns/10ps
`default_nettype none
module tcc_sensor_model (
    input  wire logic       clk,
    input  wire logic       run,
    input  wire logic       npn,
    input  wire logic [7:0] hi_cyc,
    input  wire logic [7:0] lo_cyc,
    output logic            count_pin
);
    logic [7:0] cnt_q;
    logic       phase_q;

    // ------------------------------------------------------------
    // Pulse train
    // ------------------------------------------------------------
    // Restart inactive so a new burst never begins with a runt pulse
    always_ff @(posedge clk) begin
        if (!run) begin
            cnt_q   <= 8'h00;
            phase_q <= 1'b0;
        end else if (cnt_q == (phase_q ? hi_cyc : lo_cyc) - 8'h01) begin
            cnt_q   <= 8'h00;
            phase_q <= !phase_q;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end

    // Sinking sensor pulls the line low while active
    assign count_pin = phase_q ^ npn;
endmodule
`default_nettype wire

// ===== verif/tacho_compare_hold_config_test.sv
// Self-checking bench for the tachometer compare and hold block
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin failures++; \
    $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tacho_compare_hold_config_test;
    localparam int GATE = 64;
    localparam int DEB  = 4;
    logic        clk, reset_n, count_pin, hold_key, keyprot_sw;
    logic        wr_stb, rd_stb, ctrl_out, led_hold, led_keyprot, led_out;
    logic        run, npn;
    logic [2:0]  hold_pin;
    logic [7:0]  dip_sw, addr, hi_cyc, lo_cyc;
    logic [31:0] wdata, rdata, d;
    int          failures, comparisons;

    tcc_core #(.GATE_CYC(GATE), .DEBOUNCE_CYC(DEB)) i_dut (
        .clk(clk), .reset_n(reset_n), .count_pin(count_pin),
        .hold_pin(hold_pin), .hold_key(hold_key), .keyprot_sw(keyprot_sw),
        .dip_sw(dip_sw), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .rdata(rdata), .ctrl_out(ctrl_out),
        .led_hold(led_hold), .led_keyprot(led_keyprot), .led_out(led_out)
    );
    tcc_sensor_model i_sensor (
        .clk(clk), .run(run), .npn(npn), .hi_cyc(hi_cyc), .lo_cyc(lo_cyc),
        .count_pin(count_pin)
    );

    // ------------------------------------------------------------
    // Clock and shared tasks
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic results();
        if (failures == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        wr_stb <= 1'b1;
        addr   <= a;
        wdata  <= v;
        @(posedge clk);
        wr_stb <= 1'b0;
    endtask

    // Data is taken at the edge closing the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        rd_stb <= 1'b1;
        addr   <= a;
        @(posedge clk);
        rd_stb <= 1'b0;
        @(posedge clk);
        d = rdata;
    endtask

    // Power-on: switches are only taken while leaving reset
    task automatic restart(input logic [7:0] dip);
        run      <= 1'b0;
        dip_sw   <= dip;
        npn      <= !dip[7];
        hold_pin <= dip[7] ? 3'h0 : 3'h7;
        reset_n  <= 1'b0;
        tick(5);
        `CHK("out_in_reset", 1'b0, ctrl_out | led_out | led_hold)
        reset_n <= 1'b1;
        tick(6);
    endtask

    // Bounded poll of the measurement; a miss ends the run
    task automatic wait_meas(input logic [23:0] exp);
        for (int i = 0; i < 40; i++) begin
            rd(tcc_pkg::REG_MEAS);
            if (d[23:0] === exp) return;
            tick(GATE / 2);
        end
        `CHK("meas_wait", exp, d[23:0])
        results();
    endtask

    function automatic logic cmp_exp(input int m, input int v,
                                     input int c1, input int c2);
        case (m)
            0: return (v >= c1) || (v <= c2);
            1: return (c2 <= v) && (v <= c1);
            2: return v >= c1;
            default: return v <= c1;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        restart(8'h80);
        rd(tcc_pkg::REG_CMP1);
        `CHK("cmp1_reset", 32'h0, d)
        wr(tcc_pkg::REG_CMP1, 32'hffabcdef);
        wr(tcc_pkg::REG_MEAS, 32'h00000005);
        rd(tcc_pkg::REG_CMP1);
        `CHK("cmp1_rw", 32'h00abcdef, d)
        rd(tcc_pkg::REG_MEAS);
        `CHK("meas_ro", 32'h0, d)
        rd(8'h10);
        `CHK("unmapped", 32'h0, d)
        rd(tcc_pkg::REG_STAT);
        `CHK("stat_dip", 8'h80, d[7:0])
    endtask

    // Every mode against below, above and equal limits
    task automatic t_modes();
        int c1[3] = '{10, 30, 20};
        int c2[3] = '{5, 15, 20};
        logic exp_out;
        for (int m = 0; m < 4; m++) begin
            restart({1'b1, 1'b0, 2'h0, m[1:0], 1'b1, 1'b0});
            run <= 1'b1;
            wait_meas(24'd20);
            for (int k = 0; k < 3; k++) begin
                wr(tcc_pkg::REG_CMP1, c1[k]);
                wr(tcc_pkg::REG_CMP2, c2[k]);
                tick(3 * GATE);
                exp_out = cmp_exp(m, 20, c1[k], c2[k]);
                `CHK("ctrl_mode", exp_out, ctrl_out)
                `CHK("led_out", exp_out, led_out)
                rd(tcc_pkg::REG_STAT);
                `CHK("stat_out", exp_out, d[tcc_pkg::STAT_OUT])
            end
        end
    endtask

    // Each averaging code with alternating polarity, then count rate
    task automatic t_rate_avg();
        for (int i = 0; i < 4; i++) begin
            restart({!i[0], 1'b0, i[1:0], 2'h0, 2'h0});
            run <= 1'b1;
            // Too short an average would load a value before this read
            tick((GATE << i) - GATE / 2);
            rd(tcc_pkg::REG_MEAS);
            `CHK("avg_early", 32'h0, d)
            wait_meas(24'd20);
        end
        hi_cyc <= 8'd2;
        lo_cyc <= 8'd2;
        restart(8'h80);
        run <= 1'b1;
        tick(6 * GATE);
        rd(tcc_pkg::REG_MEAS);
        `CHK("bounce_filtered", 32'h0, d)
        restart(8'h82);
        run <= 1'b1;
        wait_meas(24'd80);
        hi_cyc <= 8'd8;
        lo_cyc <= 8'd8;
    endtask

    // Each hold source alone freezes value and output
    task automatic t_hold(input logic inv);
        restart({!inv, 1'b0, 2'h0, 2'h2, 1'b1, 1'b0});
        run <= 1'b1;
        wait_meas(24'd20);
        wr(tcc_pkg::REG_CMP1, 32'd10);
        tick(3 * GATE);
        `CHK("ctrl_on", 1'b1, ctrl_out)
        for (int s = 0; s < 4; s++) begin
            if (s < 3) hold_pin <= inv ? ~(3'h1 << s) : (3'h1 << s);
            else hold_key <= 1'b1;
            tick(4);
            `CHK("led_hold_on", 1'b1, led_hold)
            run <= 1'b0;
            // New limit would turn the output off unless it is held
            wr(tcc_pkg::REG_CMP1, 32'd30);
            tick(3 * GATE);
            rd(tcc_pkg::REG_MEAS);
            `CHK("meas_frozen", 32'd20, d)
            `CHK("ctrl_frozen", 1'b1, ctrl_out)
            hold_pin <= inv ? 3'h7 : 3'h0;
            hold_key <= 1'b0;
            tick(4);
            `CHK("led_hold_off", 1'b0, led_hold)
            wait_meas(24'd0);
            tick(2);
            `CHK("ctrl_off", 1'b0, ctrl_out)
            wr(tcc_pkg::REG_CMP1, 32'd10);
            run <= 1'b1;
            wait_meas(24'd20);
            tick(2);
        end
    endtask

    // Lamp follows switch; running switch edits only show in status
    task automatic t_live();
        keyprot_sw <= 1'b1;
        tick(4);
        `CHK("led_kp_on", 1'b1, led_keyprot)
        rd(tcc_pkg::REG_STAT);
        `CHK("stat_kp", 1'b1, d[tcc_pkg::STAT_KP])
        keyprot_sw <= 1'b0;
        dip_sw     <= 8'h8c;
        tick(4);
        `CHK("led_kp_off", 1'b0, led_keyprot)
        tick(3 * GATE);
        `CHK("mode_kept", 1'b1, ctrl_out)
        rd(tcc_pkg::REG_STAT);
        `CHK("stat_live", 12'ha8c, d[11:0])
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        failures    = 0;
        comparisons = 0;
        reset_n     = 1'b0;
        hold_pin    = 3'h0;
        hold_key    = 1'b0;
        keyprot_sw  = 1'b0;
        dip_sw      = 8'h80;
        addr        = 8'h00;
        wdata       = 32'h0;
        wr_stb      = 1'b0;
        rd_stb      = 1'b0;
        run         = 1'b0;
        npn         = 1'b0;
        hi_cyc      = 8'd8;
        lo_cyc      = 8'd8;
        t_regs();
        t_modes();
        t_rate_avg();
        t_hold(1'b1);
        t_hold(1'b0);
        t_live();
        results();
    end
endmodule
`default_nettype wire
